/* File: tuner_regs_pkg.sv */
/*
  package for the tuner status and bias register slice: offsets, fields, resets, encodings.
  assumes a 32-bit apb word per register; offsets 0x11..0x18 are register indexes, byte address is four times.
*/
`default_nettype none
package tuner_regs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IDX_OSC_STATUS = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_GENERAL_STATUS = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_BIAS_ADJUST = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_FACTORY_TEST = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_CAL_WRITE = 8'h15;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h16;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 8'h17;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 8'h18;
  localparam int unsigned IDX_SHIFT = 2;
  localparam logic [7:0] BIAS_RESET = 8'h52;
  localparam logic [7:0] BIAS_MASK = 8'h7F;
  localparam logic [7:0] TEST_RESET = 8'h40;
  localparam logic [7:0] CAL_RESET = 8'h00;
  localparam int unsigned BIAS_GAIN_BIT = 6;
  localparam int unsigned BIAS_AMP_LSB = 4;
  localparam int unsigned BIAS_MIX_LSB = 2;
  localparam int unsigned BIAS_FILT_BIT = 1;
  localparam int unsigned BIAS_IF_BIT = 0;
  localparam logic [1:0] BIAS_NOMINAL = 2'h1;
  localparam logic [1:0] BIAS_LINEAR = 2'h3;
  localparam logic [2:0] WIN_LOW = 3'h0;
  localparam logic [2:0] WIN_HIGH = 3'h7;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_FAIL = 1;
  localparam int unsigned IRQ_UNLOCK = 2;
  typedef struct packed {
    logic [1:0] chosen_oscillator;
    logic [3:0] chosen_subband;
    logic autoselect_success;
    logic autoselect_idle;
  } osc_status_s;
  typedef struct packed {
    logic [1:0] empty;
    logic factory_flag_a;
    logic factory_flag_b;
    logic factory_flag_c;
    logic [2:0] tune_voltage_window;
  } general_status_s;
  typedef struct packed {
    logic empty;
    logic mixer_gain_nominal;
    logic [1:0] input_amp_bias;
    logic [1:0] mixer_bias;
    logic filter_bias_keep_one;
    logic if_amp_bias_boost;
  } bias_s;
endpackage
`default_nettype wire

/* File: tuner_status_bias_regs.sv */
/*
  apb register slice of the tuner: oscillator autoselect status, lock window, bias adjust, test and calibration bytes.
  assumes the synthesizer core drives status inputs synchronously to pclk.
*/
// Local design decision: register access over APB.
// Functional notes
// - status bits 7:6 show the oscillator now in use
// - status bits 5:2 show the chosen sub-band
// - bit 1 reads 1 only after a successful automatic selection
// - bit 0 reads 0 while autoselect runs, 1 when idle
// - lock window 000 low, 001-110 locked, 111 high
// - bias bit 6 selects nominal or reduced mixer gain
// - amp and mixer bias fields: 01 nominal, 11 most linear
// - bias bit 0 boosts if amplifier current
`timescale 1ns/1ps
`default_nettype none
module tuner_status_bias_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoselect_enable,
  input wire logic autoselect_running,
  input wire logic autoselect_found,
  input wire logic [1:0] auto_oscillator,
  input wire logic [3:0] auto_subband,
  input wire logic [1:0] manual_oscillator,
  input wire logic [3:0] manual_subband,
  input wire logic [2:0] tune_voltage_adc,
  input wire logic [2:0] factory_flags,
  output logic mixer_gain_nominal,
  output logic [1:0] input_amp_bias,
  output logic [1:0] mixer_bias,
  output logic filter_bias_keep_one,
  output logic if_amp_bias_boost,
  output logic [7:0] factory_test_value,
  output logic [7:0] calibration_write_byte,
  output logic irq
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } bus_state_e;

  function automatic logic [7:0] idx_of(input logic [9:0] a);
    idx_of = a[9:tuner_regs_pkg::IDX_SHIFT];
  endfunction

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (idx_of(a) == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_mapped(input logic [9:0] a);
    is_mapped = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      case (idx_of(a))
        tuner_regs_pkg::IDX_OSC_STATUS,
        tuner_regs_pkg::IDX_GENERAL_STATUS,
        tuner_regs_pkg::IDX_BIAS_ADJUST,
        tuner_regs_pkg::IDX_FACTORY_TEST,
        tuner_regs_pkg::IDX_CAL_WRITE,
        tuner_regs_pkg::IDX_IRQ_STATUS,
        tuner_regs_pkg::IDX_IRQ_CLEAR,
        tuner_regs_pkg::IDX_IRQ_ENABLE:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  bus_state_e bus_ff, nxt_bus;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  tuner_regs_pkg::bias_s bias_ff, nxt_bias;
  logic [7:0] test_ff, nxt_test;
  logic [7:0] cal_ff, nxt_cal;
  tuner_regs_pkg::osc_status_s osc_ff, nxt_osc;
  tuner_regs_pkg::general_status_s gen_ff, nxt_gen;
  logic [2:0] irq_stat_ff, nxt_irq_stat;
  logic [2:0] irq_en_ff, nxt_irq_en;
  logic irq_ff, nxt_irq;
  logic run_d_ff, nxt_run_d;
  logic lock_d_ff, nxt_lock_d;

  logic wr_go, mapped;
  logic wr_bias, wr_test, wr_cal, wr_en, wr_clr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [2:0] events;
  logic locked;

  // a write lands only at the access edge, and only with lane 0 strobed
  assign wr_go = (bus_ff == ST_ACCESS) && psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign mapped = is_mapped(paddr);
  assign wr_bias = wr_go && hit(paddr, tuner_regs_pkg::IDX_BIAS_ADJUST);
  assign wr_test = wr_go && hit(paddr, tuner_regs_pkg::IDX_FACTORY_TEST);
  assign wr_cal = wr_go && hit(paddr, tuner_regs_pkg::IDX_CAL_WRITE);
  assign wr_en = wr_go && hit(paddr, tuner_regs_pkg::IDX_IRQ_ENABLE);
  assign wr_clr = wr_go && hit(paddr, tuner_regs_pkg::IDX_IRQ_CLEAR);
  assign locked = (tune_voltage_adc != tuner_regs_pkg::WIN_LOW) && (tune_voltage_adc != tuner_regs_pkg::WIN_HIGH);

  // oscillator status from the core
  always_comb
  begin
    nxt_osc = osc_ff;
    nxt_osc.chosen_oscillator = autoselect_enable ? auto_oscillator : manual_oscillator;
    nxt_osc.chosen_subband = autoselect_enable ? auto_subband : manual_subband;
    nxt_osc.autoselect_success = autoselect_enable && !autoselect_running && autoselect_found;
    nxt_osc.autoselect_idle = !(autoselect_enable && autoselect_running);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_ff <= '0;
    end
    else
    begin
      osc_ff <= nxt_osc;
    end
  end

  // lock window and factory flags from the core
  always_comb
  begin
    nxt_gen = '0;
    nxt_gen.factory_flag_a = factory_flags[2];
    nxt_gen.factory_flag_b = factory_flags[1];
    nxt_gen.factory_flag_c = factory_flags[0];
    nxt_gen.tune_voltage_window = tune_voltage_adc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_ff <= '0;
    end
    else
    begin
      gen_ff <= nxt_gen;
    end
  end

  // edge history; starts idle so leaving reset raises no finish event
  always_comb
  begin
    nxt_run_d = nxt_osc.autoselect_idle;
    nxt_lock_d = locked;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_d_ff <= 1'b1;
      lock_d_ff <= 1'b0;
    end
    else
    begin
      run_d_ff <= nxt_run_d;
      lock_d_ff <= nxt_lock_d;
    end
  end

  // events: selection finished, selection failed, lock lost
  always_comb
  begin
    events = '0;
    events[tuner_regs_pkg::IRQ_DONE] = nxt_osc.autoselect_idle && !run_d_ff;
    events[tuner_regs_pkg::IRQ_FAIL] = nxt_osc.autoselect_idle && !run_d_ff && !nxt_osc.autoselect_success
      && autoselect_enable;
    events[tuner_regs_pkg::IRQ_UNLOCK] = lock_d_ff && !locked;
  end

  // reads see registered status, one cycle behind the core
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx_of(paddr))
      tuner_regs_pkg::IDX_OSC_STATUS:
        rd_byte = osc_ff;
      tuner_regs_pkg::IDX_GENERAL_STATUS:
        rd_byte = gen_ff;
      tuner_regs_pkg::IDX_BIAS_ADJUST:
        rd_byte = bias_ff;
      tuner_regs_pkg::IDX_FACTORY_TEST:
        rd_byte = test_ff;
      tuner_regs_pkg::IDX_CAL_WRITE:
        rd_byte = cal_ff;
      tuner_regs_pkg::IDX_IRQ_STATUS:
        rd_byte = {5'h00, irq_stat_ff};
      tuner_regs_pkg::IDX_IRQ_ENABLE:
        rd_byte = {5'h00, irq_en_ff};
      default:
        rd_byte = 8'h00;
    endcase
    // refused or write accesses return zero
    if (pwrite || !mapped)
      rd_byte = 8'h00;
  end

  // decode at the setup edge so the access needs no wait state
  always_comb
  begin
    nxt_bus = bus_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    case (bus_ff)
      ST_IDLE:
      begin
        if (psel && !penable)
        begin
          nxt_bus = ST_ACCESS;
          nxt_pready = 1'b1;
          nxt_pslverr = !mapped;
          nxt_prdata = {24'h00_0000, rd_byte};
        end
      end
      ST_ACCESS:
      begin
        nxt_bus = ST_IDLE;
      end
      default:
      begin
        nxt_bus = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_ff <= ST_IDLE;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      bus_ff <= nxt_bus;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // writable registers
  always_comb
  begin
    nxt_bias = bias_ff;
    nxt_test = test_ff;
    nxt_cal = cal_ff;
    nxt_irq_en = irq_en_ff;
    if (wr_bias)
      nxt_bias = wbyte & tuner_regs_pkg::BIAS_MASK;
    if (wr_test)
      nxt_test = wbyte;
    if (wr_cal)
      nxt_cal = wbyte;
    if (wr_en)
      nxt_irq_en = wbyte[2:0];
    // status indexes have no write path
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bias_ff <= tuner_regs_pkg::BIAS_RESET;
      test_ff <= tuner_regs_pkg::TEST_RESET;
      cal_ff <= tuner_regs_pkg::CAL_RESET;
      irq_en_ff <= 3'h0;
    end
    else
    begin
      bias_ff <= nxt_bias;
      test_ff <= nxt_test;
      cal_ff <= nxt_cal;
      irq_en_ff <= nxt_irq_en;
    end
  end

  // sticky event bits; set wins over a clear in the same cycle
  for (genvar b = 0; b < tuner_regs_pkg::IRQ_W; b++)
  begin : g_irq
    assign nxt_irq_stat[b] = events[b] || (irq_stat_ff[b] && !(wr_clr && wbyte[b]));
  end

  // level taken from next status and enable, so it lands with them
  always_comb
  begin
    nxt_irq = |(nxt_irq_stat & nxt_irq_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mixer_gain_nominal = bias_ff.mixer_gain_nominal;
  // bias codes out, unused codes passed untouched
  assign input_amp_bias = bias_ff.input_amp_bias;
  assign mixer_bias = bias_ff.mixer_bias;
  // no forcing; software owns this bit
  assign filter_bias_keep_one = bias_ff.filter_bias_keep_one;
  assign if_amp_bias_boost = bias_ff.if_amp_bias_boost;
  assign factory_test_value = test_ff;
  assign calibration_write_byte = cal_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

/* File: tuner_regs_sva.sv */
/*
  checker for the tuner register slice: apb answer timing, bias fields, status readback.
  assumes status inputs held steady for three cycles before a checked read.
*/
`timescale 1ns/1ps
`default_nettype none
module tuner_regs_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic autoselect_enable,
  input wire logic [1:0] manual_oscillator,
  input wire logic [3:0] manual_subband,
  input wire logic mixer_gain_nominal,
  input wire logic [1:0] input_amp_bias,
  input wire logic [1:0] mixer_bias,
  input wire logic filter_bias_keep_one,
  input wire logic if_amp_bias_boost
);
  wire [6:0] bias = {mixer_gain_nominal, input_amp_bias, mixer_bias, filter_bias_keep_one, if_amp_bias_boost};
  wire acc = psel && penable && pready;
  wire [9:0] ab = {tuner_regs_pkg::IDX_BIAS_ADJUST, 2'h0};
  wire [9:0] ao = {tuner_regs_pkg::IDX_OSC_STATUS, 2'h0};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  ready_in_access_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("access cycle without ready");
  ready_needs_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  bias_write_a: assert property (acc && pwrite && paddr == ab && pstrb[0] |=> bias == $past(pwdata[6:0]))
    else $error("bias fields not loaded");
  bias_hold_a: assert property (!(acc && pwrite) |=> $stable(bias))
    else $error("bias fields changed without write");
  bias_read_a: assert property (acc && !pwrite && paddr == ab |-> prdata == {25'h0, bias})
    else $error("bias readback differs from fields");
  wire [7:0] man_status = {manual_oscillator, manual_subband, 2'h1};
  sequence manual_read_s;
    acc && !pwrite && paddr == ao && !autoselect_enable && !$past(autoselect_enable, 3)
      && $past(manual_oscillator, 3) == manual_oscillator && $past(manual_subband, 3) == manual_subband;
  endsequence
  osc_manual_a: assert property (manual_read_s |-> prdata[7:0] == man_status)
    else $error("manual oscillator status wrong");
  unaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule
bind tuner_status_bias_regs tuner_regs_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .autoselect_enable(autoselect_enable), .manual_oscillator(manual_oscillator),
  .manual_subband(manual_subband), .mixer_gain_nominal(mixer_gain_nominal), .input_amp_bias(input_amp_bias),
  .mixer_bias(mixer_bias), .filter_bias_keep_one(filter_bias_keep_one), .if_amp_bias_boost(if_amp_bias_boost));
`default_nettype wire

/* File: tuner_status_bias_regs_tb.sv */
/*
  bench for the tuner register slice: apb tasks and directed checks.
  assumes one 200 MHz clock; status inputs settle within three cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tuner_status_bias_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic autoselect_enable, autoselect_running, autoselect_found;
  logic mixer_gain_nominal, filter_bias_keep_one, if_amp_bias_boost;
  logic [1:0] auto_oscillator, manual_oscillator, input_amp_bias, mixer_bias;
  logic [3:0] auto_subband, manual_subband, pstrb;
  logic [2:0] tune_voltage_adc, factory_flags;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] factory_test_value, calibration_write_byte, bv[3];
  int bad_count, check_count, cyc;
  tuner_status_bias_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .autoselect_enable(autoselect_enable), .autoselect_running(autoselect_running),
    .autoselect_found(autoselect_found), .auto_oscillator(auto_oscillator), .auto_subband(auto_subband),
    .manual_oscillator(manual_oscillator), .manual_subband(manual_subband), .tune_voltage_adc(tune_voltage_adc),
    .factory_flags(factory_flags), .mixer_gain_nominal(mixer_gain_nominal), .input_amp_bias(input_amp_bias),
    .mixer_bias(mixer_bias), .filter_bias_keep_one(filter_bias_keep_one), .if_amp_bias_boost(if_amp_bias_boost),
    .factory_test_value(factory_test_value), .calibration_write_byte(calibration_write_byte), .irq(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until ready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [1:0] lo = 2'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string n, input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0);
    chk(n, rd & m, e);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // whole run is under two hundred cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, autoselect_running, autoselect_found} = '0;
    {autoselect_enable, pstrb, auto_oscillator, auto_subband} = {1'b0, 4'hF, 2'h2, 4'h9};
    {manual_oscillator, manual_subband, tune_voltage_adc, factory_flags} = {2'h1, 4'h6, 3'h3, 3'h5};
    bv = '{8'h37, 8'h5E, 8'h57};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("bias reset", tuner_regs_pkg::IDX_BIAS_ADJUST, 32'hFFFFFFFF, 32'h52);
    rchk("test reset", tuner_regs_pkg::IDX_FACTORY_TEST, 32'hFFFFFFFF, 32'h40);
    rchk("cal reset", tuner_regs_pkg::IDX_CAL_WRITE, 32'hFFFFFFFF, 32'h0);
    chk("cal output", 32'(calibration_write_byte), 32'h0);
    rchk("osc manual", tuner_regs_pkg::IDX_OSC_STATUS, 32'hFFFFFFFF, 32'h59);
    xfer(1'b1, tuner_regs_pkg::IDX_OSC_STATUS, 32'hFF);
    rchk("osc after write", tuner_regs_pkg::IDX_OSC_STATUS, 32'hFF, 32'h59);
    xfer(1'b1, tuner_regs_pkg::IDX_IRQ_ENABLE, 32'h1);
    autoselect_enable <= 1'b1;
    autoselect_running <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk("osc running", tuner_regs_pkg::IDX_OSC_STATUS, 32'hFD, 32'hA4);
    autoselect_running <= 1'b0;
    autoselect_found <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk("osc success", tuner_regs_pkg::IDX_OSC_STATUS, 32'hFF, 32'hA7);
    chk("irq raised", 32'(irq), 32'h1);
    rchk("irq status", tuner_regs_pkg::IDX_IRQ_STATUS, 32'h3, 32'h1);
    xfer(1'b1, tuner_regs_pkg::IDX_IRQ_CLEAR, 32'h1);
    chk("irq cleared", 32'(irq), 32'h0);
    xfer(1'b1, tuner_regs_pkg::IDX_IRQ_ENABLE, 32'h0);
    autoselect_running <= 1'b1;
    autoselect_found <= 1'b0;
    repeat (3) @(posedge pclk);
    autoselect_running <= 1'b0;
    repeat (3) @(posedge pclk);
    rchk("osc failed", tuner_regs_pkg::IDX_OSC_STATUS, 32'hFF, 32'hA5);
    chk("irq masked", 32'(irq), 32'h0);
    rchk("irq status fail", tuner_regs_pkg::IDX_IRQ_STATUS, 32'h3, 32'h3);
    foreach (bv[i])
    begin
      xfer(1'b1, tuner_regs_pkg::IDX_BIAS_ADJUST, {24'h0, bv[i]});
      chk("bias fields", 32'({mixer_gain_nominal, input_amp_bias, mixer_bias, filter_bias_keep_one,
        if_amp_bias_boost}), 32'(bv[i]));
    end
    pstrb <= 4'h0;
    xfer(1'b1, tuner_regs_pkg::IDX_BIAS_ADJUST, 32'h56);
    pstrb <= 4'hF;
    rchk("bias no strobe", tuner_regs_pkg::IDX_BIAS_ADJUST, 32'hFFFFFFFF, 32'h57);
    xfer(1'b1, tuner_regs_pkg::IDX_BIAS_ADJUST, 32'h56, 2'h2);
    chk("unaligned err", 32'(err), 32'h1);
    xfer(1'b0, 8'hFF, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    xfer(1'b1, tuner_regs_pkg::IDX_FACTORY_TEST, 32'h40);
    chk("test value", 32'(factory_test_value), 32'h40);
    for (int i = 0; i < 8; i++)
    begin
      tune_voltage_adc <= i[2:0];
      repeat (3) @(posedge pclk);
      rchk("lock window", tuner_regs_pkg::IDX_GENERAL_STATUS, 32'hFF, 32'h28 | i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
